// ==== shared/sfpi_defines.svh ====
// Constants for the serial flash pin front end.
// Assumes inclusion by bare name from the package and the design.
`ifndef SFPI_DEFINES_SVH
`define SFPI_DEFINES_SVH
`define SFPI_QE_BIT 6
`define SFPI_BYTE_BITS 8
`define SFPI_CNT_W 4
`define SFPI_STEP_SINGLE 4'h1
`define SFPI_STEP_DUAL 4'h2
`define SFPI_STEP_QUAD 4'h4
`define SFPI_CNT_ZERO 4'h0
`define SFPI_IDLE_BYTE 8'hff
`endif

// ==== shared/sfpi_pkg.sv ====
// Types shared by the serial flash pin front end.
// Assumes the defines header is on the include path.
`include "sfpi_defines.svh"
package sfpi_pkg;
	typedef enum logic [1:0] {SFPI_LANE_SINGLE, SFPI_LANE_DUAL, SFPI_LANE_QUAD} sfpi_lane_e;
	typedef logic [`SFPI_BYTE_BITS-1:0] sfpi_byte_t;
endpackage

// ==== logic/sfpi_pin_front.sv ====
// Pin front end of a serial flash: select, lanes, protect pin, pause.
// Assumes serialClk comes from the master; core side runs on core_clk.
//
// Operation
// - Chip select high deselects and releases every output pin.
// - Deselected device sits in low power standby.
// - Chip select low selects, leaves standby, moves instructions and data.
// - No instruction accepted before a select falling edge after power up.
// - Shifted data inputs are ignored while chip select is high; the protect pin io_line_2 is still sampled.
// - Single line inbound bits on io_line_0 sampled on rising clock.
// - Single line read data driven on io_line_1 at falling clock.
// - Dual and quad lines bidirectional; sample rising, drive falling.
// - Quad uses protect pin as io_line_2 and pause pin as io_line_3.
// - Protect pin low refuses status writes; high permits them.
// - With quad_enable_bit set the protect function is off.
// - Pause while selected keeps the serial sequence intact.
// - Pause low with select low floats io_line_1.
// - Pause release resumes where the sequence stopped.
// - With quad_enable_bit set the pause function is off.
// - Clock modes 0 and 3 both supported; idle level set by master.
// - quad_enable_bit is status bit 6; one enables quad.
// - Four line mode maps the four pins to io_line_0 to io_line_3.
`timescale 1ns/100ps
`include "sfpi_defines.svh"
module sfpi_pin_front
(
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic serialClk,
	input wire logic chipSelectN,
	input wire logic [3:0] ioIn,
	output logic [3:0] ioOut,
	output logic [3:0] ioOe,
	input wire logic [7:0] statusReg,
	input wire sfpi_pkg::sfpi_lane_e laneMode,
	input wire logic driveEn,
	input wire sfpi_pkg::sfpi_byte_t txByte,
	input wire logic txLoad,
	output sfpi_pkg::sfpi_byte_t rxByte,
	output logic rxValid,
	output logic txTaken,
	output logic selected,
	output logic standby,
	output logic statusWriteOk
);
	import sfpi_pkg::*;

	// Link side: async reset while deselected or in core reset
	wire logic linkRstN = resetn & ~chipSelectN;
	logic qeS1, qeS2;
	sfpi_lane_e laneS1, laneS2;
	logic drvS1, drvS2;
	wire logic quadEnable = statusReg[`SFPI_QE_BIT];

	// Settings cross on serial clock edges; core allows two edges before a frame
	always_ff @(posedge serialClk or negedge resetn)
	begin
		if (!resetn)
		begin
			qeS1 <= 1'b0;
			qeS2 <= 1'b0;
			laneS1 <= SFPI_LANE_SINGLE;
			laneS2 <= SFPI_LANE_SINGLE;
		end
		else
		begin
			qeS1 <= quadEnable;
			qeS2 <= qeS1;
			laneS1 <= laneMode;
			laneS2 <= laneS1;
		end
	end

	// Pause pin only acts as pause when quad is off
	wire logic paused = ~ioIn[3] & ~qeS2;
	wire sfpi_lane_e laneEff = (laneS2 == SFPI_LANE_QUAD && !qeS2) ? SFPI_LANE_SINGLE : laneS2;
	wire logic [3:0] step = (laneEff == SFPI_LANE_QUAD) ? `SFPI_STEP_QUAD :
		(laneEff == SFPI_LANE_DUAL) ? `SFPI_STEP_DUAL : `SFPI_STEP_SINGLE;

	// Inbound shifter on rising edge
	logic [3:0] inCnt_q;
	sfpi_byte_t inSh_q, inSh_d, rxHold_q;
	logic rxTog_q;
	wire logic [3:0] inCntSum = inCnt_q + step;
	wire logic inDone = (inCntSum == 4'(`SFPI_BYTE_BITS));
	assign inSh_d = (laneEff == SFPI_LANE_QUAD) ? {inSh_q[3:0], ioIn[3:0]} :
		(laneEff == SFPI_LANE_DUAL) ? {inSh_q[5:0], ioIn[1:0]} : {inSh_q[6:0], ioIn[0]};

	always_ff @(posedge serialClk or negedge linkRstN)
	begin
		if (!linkRstN)
		begin
			inCnt_q <= `SFPI_CNT_ZERO;
			inSh_q <= '0;
		end
		else if (!paused)
		begin
			inCnt_q <= inDone ? `SFPI_CNT_ZERO : inCntSum;
			inSh_q <= inSh_d;
		end
	end

	// Completed byte and its toggle survive deselect
	always_ff @(posedge serialClk or negedge resetn)
	begin
		if (!resetn)
		begin
			rxHold_q <= '0;
			rxTog_q <= 1'b0;
		end
		else if (linkRstN && !paused && inDone)
		begin
			rxHold_q <= inSh_d;
			rxTog_q <= ~rxTog_q;
		end
	end

	// Outbound: controls crossed on falling edge
	logic txTogS1, txTogS2, txSeen_q;
	logic txTog_q;
	sfpi_byte_t txHold_q, outSh_q;
	logic [3:0] outCnt_q;
	logic [3:0] ioOut_q, ioOe_q;

	always_ff @(negedge serialClk or negedge resetn)
	begin
		if (!resetn)
		begin
			txTogS1 <= 1'b0;
			txTogS2 <= 1'b0;
			drvS1 <= 1'b0;
			drvS2 <= 1'b0;
		end
		else
		begin
			txTogS1 <= txTog_q;
			txTogS2 <= txTogS1;
			drvS1 <= driveEn;
			drvS2 <= drvS1;
		end
	end

	wire logic outStart = (outCnt_q == `SFPI_CNT_ZERO);
	wire logic txNew = outStart && (txTogS2 != txSeen_q);
	wire sfpi_byte_t outSrc = outStart ? (txNew ? txHold_q : `SFPI_IDLE_BYTE) : outSh_q;
	wire logic [3:0] outSum = outCnt_q + step;
	wire logic [3:0] bitsOut = (laneEff == SFPI_LANE_QUAD) ? outSrc[7:4] :
		(laneEff == SFPI_LANE_DUAL) ? {2'b00, outSrc[7:6]} : {2'b00, outSrc[7], 1'b0};
	wire logic [3:0] oeMode = (laneEff == SFPI_LANE_QUAD) ? 4'hf :
		(laneEff == SFPI_LANE_DUAL) ? 4'h3 : 4'h2;
	wire logic outRstN = linkRstN & ~paused;

	always_ff @(negedge serialClk or negedge linkRstN)
	begin
		if (!linkRstN)
		begin
			outCnt_q <= `SFPI_CNT_ZERO;
			outSh_q <= '0;
		end
		else if (!paused && drvS2)
		begin
			outCnt_q <= (outSum == 4'(`SFPI_BYTE_BITS)) ? `SFPI_CNT_ZERO : outSum;
			outSh_q <= outSrc << step;
		end
	end

	always_ff @(negedge serialClk or negedge resetn)
	begin
		if (!resetn)
			txSeen_q <= 1'b0;
		else if (linkRstN && !paused && drvS2 && txNew)
			txSeen_q <= txTogS2;
	end

	// Pin drivers released at once on deselect or pause
	always_ff @(negedge serialClk or negedge outRstN)
	begin
		if (!outRstN)
		begin
			ioOut_q <= '0;
			ioOe_q <= '0;
		end
		else
		begin
			ioOut_q <= bitsOut;
			ioOe_q <= drvS2 ? oeMode : 4'h0;
		end
	end
	assign ioOut = ioOut_q;
	assign ioOe = ioOe_q;

	// Core side synchronisers
	logic csS1, csS2, wpS1, wpS2, rxS1, rxS2, rxS3, ackS1, ackS2, ackS3;
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			// Select sync starts low so arming needs a real high level
			{csS1, csS2, wpS1, wpS2} <= 4'h0;
			{rxS1, rxS2, rxS3} <= 3'h0;
			{ackS1, ackS2, ackS3} <= 3'h0;
		end
		else
		begin
			csS1 <= chipSelectN;
			csS2 <= csS1;
			wpS1 <= ioIn[2];
			wpS2 <= wpS1;
			rxS1 <= rxTog_q;
			rxS2 <= rxS1;
			rxS3 <= rxS2;
			ackS1 <= txSeen_q;
			ackS2 <= ackS1;
			ackS3 <= ackS2;
		end
	end

	logic armed_q, frameOk_q, rxValid_q, txTaken_q, sel_q, stby_q, swOk_q;
	sfpi_byte_t rxByte_q;
	wire logic csFall = ~csS2 & ~sel_q;
	wire logic rxEvt = rxS2 ^ rxS3;

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			armed_q <= 1'b0;
			frameOk_q <= 1'b0;
			sel_q <= 1'b0;
			stby_q <= 1'b1;
			swOk_q <= 1'b0;
		end
		else
		begin
			if (csS2)
				armed_q <= 1'b1;
			if (csS2)
				frameOk_q <= 1'b0;
			else if (csFall)
				frameOk_q <= armed_q;
			// Standby until chip select has been seen high once
			sel_q <= ~csS2 & armed_q;
			stby_q <= csS2 | ~armed_q;
			swOk_q <= quadEnable | wpS2;
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rxByte_q <= '0;
			rxValid_q <= 1'b0;
			txTaken_q <= 1'b0;
			txTog_q <= 1'b0;
			txHold_q <= '0;
		end
		else
		begin
			rxValid_q <= rxEvt && frameOk_q;
			if (rxEvt)
				rxByte_q <= rxHold_q;
			txTaken_q <= ackS2 ^ ackS3;
			if (txLoad && (txTog_q == ackS2))
			begin
				txHold_q <= txByte;
				txTog_q <= ~txTog_q;
			end
		end
	end
	assign rxByte = rxByte_q;
	assign rxValid = rxValid_q;
	assign txTaken = txTaken_q;
	assign selected = sel_q;
	assign standby = stby_q;
	assign statusWriteOk = swOk_q;

	sequence seqCsHeld;
		csS2 ##1 csS2 ##1 csS2;
	endsequence

	AST_CS_RELEASE: assert property (@(posedge core_clk) disable iff (!resetn)
		seqCsHeld |-> (ioOe_q == 4'h0)) else $error("pins driven while deselected");
	AST_STANDBY: assert property (@(posedge core_clk) disable iff (!resetn)
		$rose(csS2) |=> stby_q && !sel_q) else $error("no standby after deselect");
	AST_SELECT: assert property (@(posedge core_clk) disable iff (!resetn)
		$fell(csS2) |=> sel_q && !stby_q) else $error("no select after chip select low");
	AST_ARMED: assert property (@(posedge core_clk) disable iff (!resetn)
		rxValid_q |-> armed_q && $past(frameOk_q)) else $error("byte before first select edge");
	AST_SINGLE_SAMPLE: assert property (@(posedge serialClk) disable iff (!linkRstN)
		(laneEff == SFPI_LANE_SINGLE && !paused && inDone) |=> rxHold_q[0] == $past(ioIn[0]))
		else $error("single lane bit not sampled");
	AST_WP_BLOCK: assert property (@(posedge core_clk) disable iff (!resetn)
		(!quadEnable && !wpS2) ##1 (!quadEnable && !wpS2) |=> !swOk_q) else $error("status write allowed");
	AST_QE_OVERRIDE: assert property (@(posedge core_clk) disable iff (!resetn)
		quadEnable ##1 quadEnable |=> swOk_q) else $error("protect pin active under quad");
	AST_PAUSE_FLOAT: assert property (@(negedge serialClk) disable iff (!linkRstN)
		paused |-> (ioOe_q[1] == 1'b0)) else $error("output driven while paused");
	AST_PAUSE_HOLD: assert property (@(posedge serialClk) disable iff (!linkRstN)
		paused ##1 paused |-> $stable(inCnt_q) && $stable(inSh_q)) else $error("shift moved while paused");
endmodule // sfpi_pin_front

// ==== dv/sfpi_master_model.sv ====
// SPI master model: select, mode 0 or mode 3 clock, four data lines.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/100ps
module sfpi_master_model
(
	output logic serialClk,
	output logic chipSelectN,
	output logic [3:0] ioIn
);
	initial
	begin
		serialClk = 1'b0;
		chipSelectN = 1'b1;
		ioIn = 4'b1100;
	end
	task automatic edgeOnce();
		if (serialClk)
		begin
			#40 serialClk = 1'b0;
			#80 serialClk = 1'b1;
			#40;
		end
		else
		begin
			#80 serialClk = 1'b1;
			#80 serialClk = 1'b0;
		end
	endtask
	task automatic setIdle(input logic lvl);
		serialClk = lvl;
	endtask
	task automatic frameStart();
		#200 chipSelectN = 1'b0;
		#80;
	endtask
	task automatic frameEnd();
		#80 chipSelectN = 1'b1;
		ioIn = {2'b11, ~ioIn[1:0]};
	endtask
	task automatic shift(input int w, input logic [7:0] d, input int n);
		logic [7:0] sh;
		sh = d;
		repeat (n)
		begin
			if (w == 4) ioIn = sh[7:4];
			else if (w == 2) ioIn[1:0] = sh[7:6];
			else ioIn[0] = sh[7];
			sh = sh << w;
			edgeOnce();
		end
		ioIn[0] = ~ioIn[0];
	endtask
	task automatic setCtl(input logic wp, input logic hold);
		ioIn[3:2] = {hold, wp};
	endtask
endmodule // sfpi_master_model

// ==== dv/sfpi_pin_front_tb.sv ====
// Self-checking bench for the serial flash pin front end.
// Assumes the master model drives the link side.
`timescale 1ns/100ps
module sfpi_pin_front_tb;
	import sfpi_pkg::*;
	logic core_clk, resetn, serialClk, chipSelectN, driveEn, txLoad, got;
	logic rxValid, txTaken, selected, standby, statusWriteOk;
	logic [3:0] ioIn, ioOut, ioOe;
	logic [7:0] statusReg;
	sfpi_lane_e laneMode;
	sfpi_byte_t txByte, rxByte;
	int badCount = 0;
	int nChecks = 0;
	sfpi_master_model i_sfpi_master_model (.serialClk(serialClk), .chipSelectN(chipSelectN), .ioIn(ioIn));
	sfpi_pin_front i_sfpi_pin_front (.core_clk(core_clk), .resetn(resetn), .serialClk(serialClk),
		.chipSelectN(chipSelectN), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .statusReg(statusReg),
		.laneMode(laneMode), .driveEn(driveEn), .txByte(txByte), .txLoad(txLoad), .rxByte(rxByte),
		.rxValid(rxValid), .txTaken(txTaken), .selected(selected), .standby(standby),
		.statusWriteOk(statusWriteOk));
	task automatic results();
		$display("checks %0d mismatches %0d", nChecks, badCount);
		if (badCount == 0 && nChecks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic fail(input string msg);
		badCount++;
		$display("BAD %0t %s", $time, msg);
	endtask
	task automatic core(input logic [7:0] st, input sfpi_lane_e lm, input logic de);
		@(posedge core_clk);
		#1 statusReg = st;
		laneMode = lm;
		driveEn = de;
		repeat (6) @(posedge core_clk);
		// Deselected edges carry the settings into the link
		repeat (2) i_sfpi_master_model.edgeOnce();
	endtask
	task automatic waitRx();
		got = 1'b0;
		repeat (300)
		begin
			@(posedge core_clk);
			#1 if (rxValid === 1'b1) got = 1'b1;
		end
	endtask
	task automatic rxFrame(input int w, input logic [7:0] d, input int n);
		i_sfpi_master_model.frameStart();
		fork
			i_sfpi_master_model.shift(w, d, n);
			waitRx();
		join
		i_sfpi_master_model.frameEnd();
	endtask
	task automatic tSingle();
		core(8'h00, SFPI_LANE_SINGLE, 1'b0);
		rxFrame(1, 8'ha5, 8);
		nChecks++;
		if (got !== 1'b1 || rxByte !== 8'ha5) fail("single byte");
		#100;
		nChecks++;
		if (standby !== 1'b1 || ioOe !== 4'h0) fail("deselect");
	endtask
	task automatic tIgnore();
		fork
			i_sfpi_master_model.shift(1, 8'h3c, 8);
			waitRx();
		join
		nChecks++;
		if (got !== 1'b0 || rxByte !== 8'ha5) fail("byte while deselected");
	endtask
	task automatic tQuad();
		core(8'h40, SFPI_LANE_QUAD, 1'b0);
		rxFrame(4, 8'h5c, 2);
		nChecks++;
		if (got !== 1'b1 || rxByte !== 8'h5c) fail("quad byte");
	endtask
	task automatic tDual();
		core(8'h00, SFPI_LANE_DUAL, 1'b0);
		rxFrame(2, 8'h3a, 4);
		nChecks++;
		if (got !== 1'b1 || rxByte !== 8'h3a) fail("dual byte");
	endtask
	task automatic tMode3();
		i_sfpi_master_model.setIdle(1'b1);
		core(8'h00, SFPI_LANE_SINGLE, 1'b0);
		rxFrame(1, 8'hc6, 8);
		nChecks++;
		if (got !== 1'b1 || rxByte !== 8'hc6) fail("mode 3 byte");
		i_sfpi_master_model.setIdle(1'b0);
	endtask
	task automatic tRead();
		logic [7:0] q;
		logic tk;
		tk = 1'b0;
		q = 8'h00;
		@(posedge core_clk);
		#1 txByte = 8'hc3;
		txLoad = 1'b1;
		@(posedge core_clk);
		#1 txLoad = 1'b0;
		core(8'h00, SFPI_LANE_SINGLE, 1'b1);
		i_sfpi_master_model.frameStart();
		fork
			i_sfpi_master_model.shift(1, 8'h00, 9);
			begin
				@(posedge serialClk);
				repeat (8)
				begin
					@(posedge serialClk);
					q = {q[6:0], ioOut[1]};
				end
			end
			repeat (200)
			begin
				@(posedge core_clk);
				#1 if (txTaken === 1'b1) tk = 1'b1;
			end
		join
		i_sfpi_master_model.frameEnd();
		nChecks++;
		if (q !== 8'hc3) fail("read byte");
		nChecks++;
		if (tk !== 1'b1) fail("no byte taken");
	endtask
	task automatic tProtect();
		i_sfpi_master_model.setCtl(1'b0, 1'b1);
		core(8'h00, SFPI_LANE_SINGLE, 1'b0);
		nChecks++;
		if (statusWriteOk !== 1'b0) fail("protect low");
		core(8'h40, SFPI_LANE_SINGLE, 1'b0);
		nChecks++;
		if (statusWriteOk !== 1'b1) fail("quad protect");
		i_sfpi_master_model.setCtl(1'b1, 1'b1);
		core(8'h00, SFPI_LANE_SINGLE, 1'b0);
		nChecks++;
		if (statusWriteOk !== 1'b1) fail("protect high");
	endtask
	task automatic tPause();
		core(8'h00, SFPI_LANE_SINGLE, 1'b1);
		i_sfpi_master_model.frameStart();
		fork
			begin
				i_sfpi_master_model.shift(1, 8'h96, 4);
				nChecks++;
				if (ioOe[1] !== 1'b1 || selected !== 1'b1) fail("read drive");
				i_sfpi_master_model.setCtl(1'b1, 1'b0);
				#40;
				nChecks++;
				if (ioOe[1] !== 1'b0) fail("pause float");
				i_sfpi_master_model.shift(1, 8'h00, 3);
				i_sfpi_master_model.setCtl(1'b1, 1'b1);
				i_sfpi_master_model.shift(1, 8'h60, 4);
			end
			waitRx();
		join
		i_sfpi_master_model.frameEnd();
		nChecks++;
		if (got !== 1'b1 || rxByte !== 8'h96) fail("paused byte");
	endtask
	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	initial
	begin
		#100000;
		fail("watchdog");
		results();
	end
	initial
	begin
		resetn = 1'b0;
		statusReg = 8'h00;
		laneMode = SFPI_LANE_SINGLE;
		driveEn = 1'b0;
		txByte = 8'h00;
		txLoad = 1'b0;
		repeat (4) @(posedge core_clk);
		nChecks++;
		if (standby !== 1'b1 || selected !== 1'b0 || ioOe !== 4'h0) fail("reset state");
		#1 resetn = 1'b1;
		tSingle();
		tIgnore();
		tQuad();
		tDual();
		tMode3();
		tProtect();
		tPause();
		tRead();
		results();
	end
endmodule // sfpi_pin_front_tb
